/* pkg/sas_regs.svh */
// Purpose: Register offsets, field positions, reset values and timing for the SAR sequencer
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses
`ifndef SAS_REGS_SVH
`define SAS_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SAS_CTRL_OFS 12'h000
`define SAS_RESULT_OFS 12'h004
`define SAS_FLAG_OFS 12'h008
`define SAS_ENABLE_OFS 12'h00C
`define SAS_POWER_OFS 12'h010

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define SAS_ON_BIT 0
`define SAS_GO_BIT 1
`define SAS_CHS_LO 2
`define SAS_CHS_HI 4
`define SAS_CKS_LO 5
`define SAS_CKS_HI 7

// ----------------------------------------
// Reset values and encodings
// ----------------------------------------
`define SAS_CTRL_RST 8'h00
`define SAS_RESULT_RST 8'h00
`define SAS_CHS_TEMP 3'h6
`define SAS_CHS_FREF 3'h7

// ----------------------------------------
// Timing: half bit periods per conversion (9.5 bit periods)
// ----------------------------------------
`define SAS_CONV_HALVES 5'h13
`define SAS_RC_DELAY_INSTR 1
`define SAS_INSTR_CYCLES 4

`endif

/* pkg/sas_pkg.sv */
// Purpose: Types for the SAR sequencer
// Assumes: Nothing
// Notes: Constants live in sas_regs.svh
package sas_pkg;

    typedef enum logic [1:0] {
        SAS_IDLE,
        SAS_DELAY,
        SAS_CONV
    } sas_state_t;

    typedef struct packed {
        logic [2:0] clock_sel;
        logic [2:0] channel_sel;
        logic go;
        logic on;
    } sas_ctrl_t;

    typedef struct packed {
        logic [4:0] mux_onehot;
        logic sample;
        logic [7:0] trial;
    } sas_analog_t;

endpackage : sas_pkg

/* verilog/sas_sequencer.sv */
// Purpose: Control and sequencing for an 8-bit SAR converter, APB slave
// Assumes: Comparator result synchronised here; dedicated RC clock given as a pin
// Notes: Half bit-period tick drives the approximation
//
// Behaviour
// - Successive approximation yields an 8-bit code stored in result register.
// - Channel select routes one of five sources to the sample-and-hold.
// - 000-010 pins, 110 temperature, 111 fixed reference, 011-101 nothing.
// - Supply is the only reference; fixed reference only as input channel.
// - Clock select picks /2,/4,/8,/16,/32,/64 or dedicated RC clock.
// - A conversion lasts nine and a half bit periods.
// - Completion flag sets on every conversion end regardless of enable.
// - Hardware never clears completion flag; software clears it.
// - Enabled completion raises interrupt, even asleep, and wakes the device.
// - Works only while converter on; writing go starts a conversion.
// - On finish clear go, set flag, load result.
// - Go cleared mid-conversion aborts; unresolved bits copy last resolved bit.
// - Reset returns all registers to reset values, aborting any conversion.
// - RC clock selected delays start by one instruction cycle.
// - Asleep with RC and interrupt disabled, power down after finishing.
// - Sleep with system-derived clock aborts conversion and powers down.
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "sas_regs.svh"

module sas_sequencer
    import sas_pkg::*;
#(
    parameter int INSTR_CYCLES = `SAS_INSTR_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Device status and analog side
    input wire logic sleep_mode,
    input wire logic rc_clock_pin,
    input wire logic comparator,
    output sas_analog_t analog,
    output logic converter_powered,
    output logic conv_irq
);

    sas_ctrl_t ctrl;
    sas_state_t state;
    logic [7:0] conversion_result_reg;
    logic conv_done_flag;
    logic conv_irq_enable;
    logic asleep_off;
    logic [1:0] cmp_sync;
    logic [1:0] rc_sync;
    logic rc_prev;
    logic [5:0] div_cnt;
    logic [5:0] div_max;
    logic half_tick;
    logic [4:0] halves;
    logic [2:0] bit_idx;
    logic [7:0] trial;
    logic [7:0] resolved;
    logic [7:0] abort_code;
    logic [7:0] delay_cnt;
    logic use_rc;
    logic wr;
    logic rd;
    logic go_write;
    logic go_clear_write;
    logic finish;
    logic abort;
    logic last_bit;

    // ----------------------------------------
    // Synchronisers
    // ----------------------------------------
    always_ff @(posedge clock) begin
        cmp_sync <= {cmp_sync[0], comparator};
        rc_sync <= {rc_sync[0], rc_clock_pin};
        rc_prev <= rc_sync[1];
    end

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign go_write = wr && paddr == `SAS_CTRL_OFS && pwdata[`SAS_GO_BIT] && pwdata[`SAS_ON_BIT];
    assign go_clear_write = wr && paddr == `SAS_CTRL_OFS &&
        !(pwdata[`SAS_GO_BIT] && pwdata[`SAS_ON_BIT]);
    assign use_rc = ctrl.clock_sel[1:0] == 2'h3;

    // ----------------------------------------
    // Conversion clock divider
    // ----------------------------------------
    always_comb begin
        unique case (ctrl.clock_sel)
            3'h0: div_max = 6'h00;
            3'h4: div_max = 6'h01;
            3'h1: div_max = 6'h03;
            3'h5: div_max = 6'h07;
            3'h2: div_max = 6'h0F;
            3'h6: div_max = 6'h1F;
            default: div_max = 6'h00;
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst || state != SAS_CONV || div_cnt == div_max) begin
            div_cnt <= 6'h00;
        end else begin
            div_cnt <= div_cnt + 6'h01;
        end
    end

    // Half bit period from divider or each RC edge
    assign half_tick = state == SAS_CONV &&
        (use_rc ? (rc_sync[1] != rc_prev) : div_cnt == div_max);

    assign last_bit = halves == `SAS_CONV_HALVES - 5'h01;
    assign finish = half_tick && last_bit;
    assign abort = state != SAS_IDLE && (go_clear_write || (sleep_mode && !use_rc));

    // ----------------------------------------
    // Sequencer state
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            state <= SAS_IDLE;
            halves <= 5'h00;
            delay_cnt <= 8'h00;
        end else begin
            unique case (state)
                SAS_IDLE: begin
                    halves <= 5'h00;
                    if (go_write && ctrl.on && !asleep_off) begin
                        if (use_rc) begin
                            state <= SAS_DELAY;
                            delay_cnt <= 8'(INSTR_CYCLES * `SAS_RC_DELAY_INSTR - 1);
                        end else begin
                            state <= SAS_CONV;
                        end
                    end
                end
                SAS_DELAY: begin
                    if (abort || !ctrl.on) begin
                        state <= SAS_IDLE;
                    end else if (delay_cnt == 8'h00) begin
                        state <= SAS_CONV;
                    end else begin
                        delay_cnt <= delay_cnt - 8'h01;
                    end
                end
                SAS_CONV: begin
                    if (abort || finish || !ctrl.on) begin
                        state <= SAS_IDLE;
                    end else if (half_tick) begin
                        halves <= halves + 5'h01;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // Successive approximation
    // ----------------------------------------
    // Half 0 samples, then each bit takes two halves; compare on odd halves
    always_ff @(posedge clock) begin
        if (srst || state != SAS_CONV) begin
            trial <= 8'h80;
            resolved <= 8'h00;
            bit_idx <= 3'h7;
        end else if (half_tick && halves[0] && halves < 5'h11) begin
            resolved[bit_idx] <= cmp_sync[1];
            trial[bit_idx] <= cmp_sync[1];
            if (bit_idx != 3'h0) begin
                trial[bit_idx - 3'h1] <= 1'b1;
                bit_idx <= bit_idx - 3'h1;
            end
        end
    end

    // Unresolved bits copy the last resolved bit
    // Index stays at zero once bit 0 resolves, so halves tells the two apart
    always_comb begin
        abort_code = resolved;
        if (bit_idx == 3'h7) begin
            abort_code = 8'h00;
        end else if (bit_idx != 3'h0 || halves < 5'h10) begin
            for (int i = 0; i < 7; i++) begin
                if (3'(i) <= bit_idx) begin
                    abort_code[i] = resolved[bit_idx + 3'h1];
                end
            end
        end
    end

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            ctrl <= `SAS_CTRL_RST;
        end else begin
            if (wr && paddr == `SAS_CTRL_OFS) begin
                ctrl.clock_sel <= pwdata[`SAS_CKS_HI:`SAS_CKS_LO];
                ctrl.channel_sel <= pwdata[`SAS_CHS_HI:`SAS_CHS_LO];
                ctrl.on <= pwdata[`SAS_ON_BIT];
                ctrl.go <= pwdata[`SAS_GO_BIT] && pwdata[`SAS_ON_BIT] && ctrl.on && !asleep_off;
            end
            if (finish || (sleep_mode && !use_rc && state != SAS_IDLE)) begin
                ctrl.go <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Result, flag and enable
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            conversion_result_reg <= `SAS_RESULT_RST;
        end else if (finish) begin
            conversion_result_reg <= resolved;
        end else if (state == SAS_CONV && go_clear_write) begin
            conversion_result_reg <= abort_code;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            conv_done_flag <= 1'b0;
        end else if (finish) begin
            conv_done_flag <= 1'b1;
        end else if (wr && paddr == `SAS_FLAG_OFS && !pwdata[0]) begin
            conv_done_flag <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            conv_irq_enable <= 1'b0;
            conv_irq <= 1'b0;
        end else begin
            if (wr && paddr == `SAS_ENABLE_OFS) begin
                conv_irq_enable <= pwdata[0];
            end
            conv_irq <= conv_done_flag && conv_irq_enable;
        end
    end

    // ----------------------------------------
    // Power in sleep
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (srst || !sleep_mode) begin
            asleep_off <= 1'b0;
        end else if (!use_rc && state != SAS_DELAY) begin
            asleep_off <= 1'b1;
        end else if (finish && !conv_irq_enable) begin
            asleep_off <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            converter_powered <= 1'b0;
            analog <= '0;
        end else begin
            converter_powered <= ctrl.on && !asleep_off;
            analog.sample <= state == SAS_CONV && halves == 5'h00;
            analog.trial <= trial;
            unique case (ctrl.channel_sel)
                3'h0: analog.mux_onehot <= 5'h01;
                3'h1: analog.mux_onehot <= 5'h02;
                3'h2: analog.mux_onehot <= 5'h04;
                `SAS_CHS_TEMP: analog.mux_onehot <= 5'h08;
                `SAS_CHS_FREF: analog.mux_onehot <= 5'h10;
                default: analog.mux_onehot <= 5'h00;
            endcase
        end
    end

    // ----------------------------------------
    // APB read and response
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && (paddr > `SAS_POWER_OFS || paddr[1:0] != 2'h0);
            if (rd) begin
                unique case (paddr)
                    `SAS_CTRL_OFS: prdata <= {24'h000000, ctrl};
                    `SAS_RESULT_OFS: prdata <= {24'h000000, conversion_result_reg};
                    `SAS_FLAG_OFS: prdata <= {31'h0, conv_done_flag};
                    `SAS_ENABLE_OFS: prdata <= {31'h0, conv_irq_enable};
                    `SAS_POWER_OFS: prdata <= {31'h0, converter_powered};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_done_sets_flag;
        @(posedge clock) disable iff (srst) finish |=> conv_done_flag && !ctrl.go;
    endproperty
    a_done_sets_flag: assert property (p_done_sets_flag) else $error("flag not set at end");

    property p_flag_sticky;
        @(posedge clock) disable iff (srst)
            conv_done_flag && !(wr && paddr == `SAS_FLAG_OFS) |=> conv_done_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared by hardware");

    property p_irq_follows;
        @(posedge clock) disable iff (srst)
            conv_done_flag && conv_irq_enable |=> conv_irq;
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("irq missing");

    property p_rc_delay;
        @(posedge clock) disable iff (srst)
            state == SAS_IDLE && go_write && ctrl.on && !asleep_off && use_rc
            |=> state == SAS_DELAY;
    endproperty
    a_rc_delay: assert property (p_rc_delay) else $error("rc start not delayed");

    property p_sleep_abort;
        @(posedge clock) disable iff (srst)
            sleep_mode && !use_rc && state == SAS_CONV |=> state == SAS_IDLE ##1 !ctrl.go;
    endproperty
    a_sleep_abort: assert property (p_sleep_abort) else $error("sleep did not abort");

    property p_off_no_start;
        @(posedge clock) disable iff (srst)
            state == SAS_IDLE && !ctrl.on |=> state == SAS_IDLE;
    endproperty
    a_off_no_start: assert property (p_off_no_start) else $error("started while off");

    property p_go_busy;
        @(posedge clock) disable iff (srst)
            state == SAS_CONV && !$rose(state == SAS_CONV) && !abort |-> ctrl.go;
    endproperty
    a_go_busy: assert property (p_go_busy) else $error("go low while busy");

    property p_mux_ref;
        @(posedge clock) disable iff (srst)
            ctrl.channel_sel == `SAS_CHS_FREF |=> analog.mux_onehot == 5'h10;
    endproperty
    a_mux_ref: assert property (p_mux_ref) else $error("channel map wrong");

endmodule : sas_sequencer

/* verif/sas_analog_model.sv */
// Purpose: Analog mux and comparator model
// Assumes: Levels are codes relative to the supply
// Notes: No source selected reads as level zero
`timescale 1ns/1ps

module sas_analog_model
    import sas_pkg::*;
(
    // Clock
    input wire logic clock,
    // Converter side
    input wire sas_analog_t analog,
    output logic comparator
);
    logic [7:0] level;

    always_comb begin
        case (analog.mux_onehot)
            5'h01: level = 8'h5A;
            5'h02: level = 8'hC3;
            5'h04: level = 8'h01;
            5'h08: level = 8'h80;
            5'h10: level = 8'hFF;
            default: level = 8'h00;
        endcase
    end

    // Comparator settles one clock after the trial code
    always_ff @(posedge clock) begin
        comparator <= (level >= analog.trial);
    end
endmodule : sas_analog_model

/* verif/sas_sequencer_test.sv */
// Purpose: Self-checking bench for the SAR sequencer
// Assumes: APB master driven on rising edges
// Notes: RC clock pin toggles every sixteen system clocks
`timescale 1ns/1ps
`include "sas_regs.svh"

module sas_sequencer_test;
    import sas_pkg::*;
    logic clock = 1'h0;
    logic srst = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sleep_mode = 1'h0;
    logic [4:0] rc_div = 5'h00;
    logic comparator;
    sas_analog_t analog;
    logic converter_powered;
    logic conv_irq;
    logic [31:0] rdata;
    logic rerr;
    int miscompares = 0;
    int num_checks = 0;
    // Too-short bit periods only see full or empty scale, where settling cannot matter
    logic [2:0] cks [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
    logic [2:0] channel_select [8] = '{3'h3, 3'h7, 3'h0, 3'h1, 3'h2, 3'h5, 3'h6, 3'h4};
    logic [7:0] res [8] = '{8'h00, 8'hFF, 8'h5A, 8'hC3, 8'h01, 8'h00, 8'h80, 8'h00};
    logic [4:0] hot [8] = '{5'h00, 5'h10, 5'h01, 5'h02, 5'h04, 5'h00, 5'h08, 5'h00};
    int half [8] = '{1, 2, 4, 8, 16, 32, 0, 0};

    always #20 clock = ~clock;
    always @(posedge clock) rc_div <= rc_div + 5'h01;

    sas_sequencer #(.INSTR_CYCLES(4)) dut (
        .clock(clock), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode),
        .rc_clock_pin(rc_div[4]), .comparator(comparator), .analog(analog),
        .converter_powered(converter_powered), .conv_irq(conv_irq)
    );

    sas_analog_model model (.clock(clock), .analog(analog), .comparator(comparator));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic hang();
        miscompares++;
        $display("unexpected at %0t: wait ran out", $time);
        complete_run();
    endtask : hang

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) hang();
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clock);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'h1, a, {24'h0, d});
    endtask : wr

    task automatic rd(input logic [11:0] a);
        apb(1'h0, a, 32'h0);
    endtask : rd

    task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
        int n;
        n = 0;
        do begin
            rd(a);
            n++;
        end while ((rdata & m) !== v && n < 500);
        if (n >= 500) hang();
    endtask : poll

    task automatic chk_reset();
        for (int i = 0; i < 5; i++) begin
            rd(12'(4 * i));
            cmp(rdata, 32'h0);
        end
        cmp(32'(converter_powered), 32'h0);
    endtask : chk_reset

    function automatic logic [7:0] part(input logic [7:0] v, input int k);
        part = v;
        for (int b = 7 - k; b >= 0; b--) part[b] = v[8 - k];
    endfunction : part

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [7:0] c;
        int n;
        logic ok;
        logic smp;
        repeat (4) @(posedge clock);
        srst <= 1'h0;
        @(posedge clock);
        chk_reset();
        rd(12'h014);
        cmp(32'(rerr), 32'h1);
        cmp(rdata, 32'h0);
        wr(`SAS_ENABLE_OFS, 8'h01);
        for (int i = 0; i < 8; i++) begin
            c = {cks[i], channel_select[i], 2'h1};
            wr(`SAS_CTRL_OFS, c);
            @(posedge clock);
            cmp(32'(analog.mux_onehot), 32'(hot[i]));
            repeat (8) @(posedge clock);
            wr(`SAS_CTRL_OFS, c | 8'h02);
            n = 0;
            smp = 1'h0;
            while (conv_irq !== 1'b1 && n < 3000) begin
                @(posedge clock);
                smp |= analog.sample;
                n++;
            end
            if (n >= 3000) hang();
            cmp(32'(smp), 32'h1);
            if (half[i] != 0) cmp(32'(n >= 19 * half[i] - 2 && n <= 19 * half[i] + 6), 32'h1);
            rd(`SAS_CTRL_OFS);
            cmp(rdata & 32'h2, 32'h0);
            rd(`SAS_RESULT_OFS);
            cmp(rdata, 32'(res[i]));
            rd(`SAS_FLAG_OFS);
            cmp(rdata, 32'h1);
            wr(`SAS_FLAG_OFS, 8'h01);
            rd(`SAS_FLAG_OFS);
            cmp(rdata, 32'h1);
            wr(`SAS_FLAG_OFS, 8'h00);
            rd(`SAS_FLAG_OFS);
            cmp(rdata, 32'h0);
            cmp(32'(conv_irq), 32'h0);
        end
        $display("test table done");
        wr(`SAS_CTRL_OFS, 8'h00);
        wr(`SAS_CTRL_OFS, 8'h03);
        rd(`SAS_CTRL_OFS);
        cmp(rdata & 32'h2, 32'h0);
        repeat (50) @(posedge clock);
        rd(`SAS_FLAG_OFS);
        cmp(rdata, 32'h0);
        $display("test same write done");
        wr(`SAS_CTRL_OFS, 8'hC5);
        wr(`SAS_CTRL_OFS, 8'hC7);
        repeat (150) @(posedge clock);
        rd(`SAS_CTRL_OFS);
        cmp(rdata & 32'h2, 32'h2);
        wr(`SAS_CTRL_OFS, 8'hC5);
        rd(`SAS_CTRL_OFS);
        cmp(rdata & 32'h2, 32'h0);
        rd(`SAS_RESULT_OFS);
        ok = 1'h0;
        for (int k = 1; k < 8; k++) ok |= (rdata === 32'(part(8'hC3, k)));
        cmp(32'(ok), 32'h1);
        $display("test abort done");
        wr(`SAS_CTRL_OFS, 8'hC7);
        repeat (40) @(posedge clock);
        sleep_mode <= 1'h1;
        repeat (10) @(posedge clock);
        cmp(32'(converter_powered), 32'h0);
        rd(`SAS_CTRL_OFS);
        cmp(rdata & 32'h3, 32'h1);
        sleep_mode <= 1'h0;
        wr(`SAS_FLAG_OFS, 8'h00);
        $display("test sleep abort done");
        wr(`SAS_ENABLE_OFS, 8'h00);
        wr(`SAS_CTRL_OFS, 8'hE1);
        wr(`SAS_CTRL_OFS, 8'hE3);
        sleep_mode <= 1'h1;
        poll(`SAS_FLAG_OFS, 32'h1, 32'h1);
        repeat (4) @(posedge clock);
        cmp(32'(converter_powered), 32'h0);
        cmp(32'(conv_irq), 32'h0);
        rd(`SAS_CTRL_OFS);
        cmp(rdata & 32'h3, 32'h1);
        rd(`SAS_RESULT_OFS);
        cmp(rdata, 32'h5A);
        sleep_mode <= 1'h0;
        $display("test sleep rc done");
        wr(`SAS_CTRL_OFS, 8'hC7);
        repeat (60) @(posedge clock);
        srst <= 1'h1;
        repeat (2) @(posedge clock);
        srst <= 1'h0;
        @(posedge clock);
        chk_reset();
        $display("test mid reset done");
        complete_run();
    end
endmodule : sas_sequencer_test
